// ==== src/rsc_map.svh ====
// constants of the receiver start-up controller: frame lengths, defaults, register map
// assumes a 32-bit plain register port with byte addresses
`ifndef RSC_MAP_SVH
`define RSC_MAP_SVH

// bits per frame: data field plus four coding bits
`define RSC_FRAME_BITS_W20 5'h18
`define RSC_FRAME_BITS_W16 5'h14

// error-free frames needed before the phase detector takes over
`define RSC_LOCK_FRAMES_RST 4'h8

// register byte addresses
`define RSC_ADDR_CTRL 4'h0
`define RSC_ADDR_STATUS 4'h4

// control fields
`define RSC_CTRL_RESTART_BIT 0
`define RSC_CTRL_LOCK_LSB 4
`define RSC_CTRL_LOCK_MSB 7

// status fields
`define RSC_STAT_LO_BIT 0
`define RSC_STAT_HI_BIT 1
`define RSC_STAT_LINK_N_BIT 2
`define RSC_STAT_PHASE_BIT 3
`define RSC_STAT_HOLD_BIT 4

`endif

// ==== src/rsc_pkg.sv ====
// types of the receiver start-up controller
// uses nothing from rsc_map.svh; the state encodings are set here
package rsc_pkg;

   // start-up states; status pins are derived from these
   typedef enum logic [2:0] {
      RSC_ST_ACQUIRE = 3'b001,
      RSC_ST_PHASE = 3'b010,
      RSC_ST_ACTIVE = 3'b100
   } rsc_state_type;

endpackage

// ==== src/rsc_startup.sv ====
// receiver start-up state machine, frame-rate strobe and test-clock retiming
// assumes all inputs synchronous to sys_clk_i; one sys_clk_i cycle is one vco bit time

`timescale 1ns/1ps
`default_nettype none
`include "rsc_map.svh"

module rsc_startup
   import rsc_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic arst_n_i,
   input wire logic host_startup_reset_n_i,
   input wire logic lock_startup_reset_n_i,
   input wire logic test_clock_select_i,
   input wire logic external_test_clock_i,
   input wire logic word20_mode_i,
   input wire logic data_frame_valid_i,
   input wire logic control_frame_valid_i,
   input wire logic fill_frame_kind_i,
   input wire logic frame_error_i,
   input wire logic freq_detector_disable_i,
   input wire logic link_active_i,
   input wire logic [3:0] reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [31:0] reg_rdata_o,
   output logic startup_state_bit_lo_o,
   output logic startup_state_bit_hi_o,
   output logic recovered_frame_strobe_o,
   output logic link_up_n_o,
   output logic pll_phase_mode_o,
   output logic pll_restart_o
);

   // --------------------------------------------------------------
   // helpers
   // --------------------------------------------------------------
   function automatic logic [4:0] frame_len(input logic w20);
      frame_len = w20 ? `RSC_FRAME_BITS_W20 : `RSC_FRAME_BITS_W16;
   endfunction

   // --------------------------------------------------------------
   // bit clock selection and frame divider
   // --------------------------------------------------------------
   logic external_test_clock_q;
   logic [4:0] bit_cnt;
   logic [4:0] next_bit_cnt;
   logic next_strobe;
   logic bit_tick;
   logic frame_tick;
   logic [4:0] flen;

   always_comb begin
      flen = frame_len(word20_mode_i);
      // the test clock is a plain synchronous input, so its rising edge marks a bit
      bit_tick = test_clock_select_i ? (external_test_clock_i & ~external_test_clock_q) : 1'b1;
      frame_tick = bit_tick && (bit_cnt == flen - 5'h1);
      next_bit_cnt = bit_cnt;
      if (frame_tick || bit_cnt >= flen) begin
         next_bit_cnt = 5'h0;
      end else if (bit_tick) begin
         next_bit_cnt = bit_cnt + 5'h1;
      end
      // strobe high over the first half frame, so its rising edge is the boundary
      next_strobe = next_bit_cnt < {1'b0, flen[4:1]};
   end

   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         external_test_clock_q <= 1'b0;
         bit_cnt <= 5'h0;
         recovered_frame_strobe_o <= 1'b0;
      end else begin
         external_test_clock_q <= external_test_clock_i;
         bit_cnt <= next_bit_cnt;
         recovered_frame_strobe_o <= next_strobe;
      end
   end

   // --------------------------------------------------------------
   // start-up state machine
   // --------------------------------------------------------------
   rsc_state_type state;
   rsc_state_type next_state;
   logic [3:0] good_cnt;
   logic [3:0] next_good_cnt;
   logic next_hold;
   logic next_link_up_n;
   logic sm_rst_n;
   logic sw_restart;
   logic [3:0] lock_thr;

   always_comb begin
      sm_rst_n = host_startup_reset_n_i & lock_startup_reset_n_i;
      next_state = state;
      next_good_cnt = good_cnt;
      // hold is set at once but only cleared on a frame boundary
      next_hold = pll_restart_o;
      if (!sm_rst_n || sw_restart) begin
         next_hold = 1'b1;
      end else if (frame_tick) begin
         next_hold = 1'b0;
      end
      if (next_hold) begin
         next_state = RSC_ST_ACQUIRE;
         next_good_cnt = 4'h0;
      end else if (frame_tick) begin
         unique case (state)
            RSC_ST_ACQUIRE: begin
               if (frame_error_i) begin
                  next_good_cnt = 4'h0;
                  // a zero threshold acts as one, never as sixteen
               end else if (good_cnt + 4'h1 >= lock_thr) begin
                  // fd goes off here, one state before send enable
                  next_state = RSC_ST_PHASE;
                  next_good_cnt = 4'h0;
               end else begin
                  next_good_cnt = good_cnt + 4'h1;
               end
            end
            RSC_ST_PHASE: begin
               if (frame_error_i) begin
                  next_state = RSC_ST_ACQUIRE;
               end else if (data_frame_valid_i || control_frame_valid_i || fill_frame_kind_i) begin
                  next_state = RSC_ST_ACTIVE;
               end
            end
            RSC_ST_ACTIVE: begin
               // leaves only through a reset or a software restart; higher layers restart on bad data
               next_state = RSC_ST_ACTIVE;
            end
            default: begin
               next_state = RSC_ST_ACQUIRE;
            end
         endcase
      end
      next_link_up_n = frame_tick ? ~link_active_i : link_up_n_o;
   end

   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         state <= RSC_ST_ACQUIRE;
         good_cnt <= 4'h0;
         pll_restart_o <= 1'b1;
         startup_state_bit_lo_o <= 1'b0;
         startup_state_bit_hi_o <= 1'b0;
         link_up_n_o <= 1'b1;
         pll_phase_mode_o <= 1'b0;
      end else begin
         state <= next_state;
         good_cnt <= next_good_cnt;
         pll_restart_o <= next_hold;
         // lo: fill select and detector disable; hi: send enable and active
         startup_state_bit_lo_o <= (next_state != RSC_ST_ACQUIRE);
         startup_state_bit_hi_o <= (next_state == RSC_ST_ACTIVE);
         link_up_n_o <= next_link_up_n;
         pll_phase_mode_o <= freq_detector_disable_i;
      end
   end

   // --------------------------------------------------------------
   // register port
   // --------------------------------------------------------------
   logic [3:0] next_lock_thr;
   logic next_sw_restart;
   logic [31:0] next_rdata;

   always_comb begin
      next_lock_thr = lock_thr;
      next_sw_restart = 1'b0;
      next_rdata = 32'h0;
      if (reg_wr_i && reg_addr_i == `RSC_ADDR_CTRL) begin
         next_lock_thr = reg_wdata_i[`RSC_CTRL_LOCK_MSB:`RSC_CTRL_LOCK_LSB];
         next_sw_restart = reg_wdata_i[`RSC_CTRL_RESTART_BIT];
      end
      if (reg_rd_i) begin
         unique case (reg_addr_i)
            `RSC_ADDR_CTRL: begin
               next_rdata[`RSC_CTRL_LOCK_MSB:`RSC_CTRL_LOCK_LSB] = lock_thr;
            end
            `RSC_ADDR_STATUS: begin
               next_rdata[`RSC_STAT_LO_BIT] = startup_state_bit_lo_o;
               next_rdata[`RSC_STAT_HI_BIT] = startup_state_bit_hi_o;
               next_rdata[`RSC_STAT_LINK_N_BIT] = link_up_n_o;
               next_rdata[`RSC_STAT_PHASE_BIT] = pll_phase_mode_o;
               next_rdata[`RSC_STAT_HOLD_BIT] = pll_restart_o;
            end
            default: begin
               next_rdata = 32'h0;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         lock_thr <= `RSC_LOCK_FRAMES_RST;
         sw_restart <= 1'b0;
         reg_rdata_o <= 32'h0;
      end else begin
         lock_thr <= next_lock_thr;
         sw_restart <= next_sw_restart;
         reg_rdata_o <= next_rdata;
      end
   end

   // --------------------------------------------------------------
   // checks
   // --------------------------------------------------------------
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (!arst_n_i);

   property p_rst_acq;
      !sm_rst_n |=> (state == RSC_ST_ACQUIRE) && !startup_state_bit_lo_o;
   endproperty
   a_rst_acq: assert property (p_rst_acq) else $error("reset did not force acquisition");

   property p_restart;
      !sm_rst_n |=> pll_restart_o;
   endproperty
   a_restart: assert property (p_restart) else $error("no pll restart on reset");

   property p_release;
      pll_restart_o && !frame_tick && sm_rst_n && !sw_restart |=> pll_restart_o;
   endproperty
   a_release: assert property (p_release) else $error("reset released off boundary");

   property p_lock_hold;
      !lock_startup_reset_n_i [*2] |=> !startup_state_bit_lo_o && !startup_state_bit_hi_o;
   endproperty
   a_lock_hold: assert property (p_lock_hold) else $error("left start-up before tx lock");

   property p_stat_state;
      startup_state_bit_lo_o == (state != RSC_ST_ACQUIRE);
   endproperty
   a_stat_state: assert property (p_stat_state) else $error("status low bit wrong");

   property p_fd_first;
      $rose(startup_state_bit_hi_o) |-> $past(startup_state_bit_lo_o, 1);
   endproperty
   a_fd_first: assert property (p_fd_first) else $error("data enabled with fd on");

   property p_stat_code;
      startup_state_bit_hi_o |-> startup_state_bit_lo_o;
   endproperty
   a_stat_code: assert property (p_stat_code) else $error("illegal status code");

   property p_strobe;
      frame_tick |=> recovered_frame_strobe_o && !$past(recovered_frame_strobe_o);
   endproperty
   a_strobe: assert property (p_strobe) else $error("strobe not rising at frame");

   property p_external_test_clock;
      test_clock_select_i && !(external_test_clock_i && !external_test_clock_q) |=> $stable(bit_cnt);
   endproperty
   a_external_test_clock: assert property (p_external_test_clock) else $error("bit advanced without test clock");

   property p_link;
      frame_tick |=> link_up_n_o == !$past(link_active_i);
   endproperty
   a_link: assert property (p_link) else $error("link-up not retimed copy");

   property p_link_keep;
      !frame_tick |=> $stable(link_up_n_o);
   endproperty
   a_link_keep: assert property (p_link_keep) else $error("link-up moved off frame");

   property p_hold_acq;
      pll_restart_o |-> !startup_state_bit_lo_o && !startup_state_bit_hi_o;
   endproperty
   a_hold_acq: assert property (p_hold_acq) else $error("hold not in acquire");

   property p_phase;
      pll_phase_mode_o == $past(freq_detector_disable_i);
   endproperty
   a_phase: assert property (p_phase) else $error("phase mode not a copy");

   property p_rdata_idle;
      !reg_rd_i |=> reg_rdata_o == 32'h0;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero");

   c_active: cover property ($rose(startup_state_bit_hi_o));
   c_restart: cover property (startup_state_bit_hi_o ##1 !host_startup_reset_n_i);
   c_external_test_clock_frame: cover property (test_clock_select_i && frame_tick);
   c_phase: cover property ($rose(startup_state_bit_lo_o));
   c_sw_restart: cover property (sw_restart && startup_state_bit_hi_o);

endmodule

`default_nettype wire

// ==== sim/rsc_far_model.sv ====
// far side of the start-up controller: transmitter lock and the far receiver
// assumes frame indications are latched on the rising recovered strobe
`timescale 1ns/1ps
`default_nettype none
module rsc_far_model #(parameter int LOCK_DLY = 30) (
   input wire logic sys_clk_i,
   input wire logic arst_n_i,
   input wire logic strobe_i,
   input wire logic fill_select_i,
   input wire logic err_inj_i,
   output logic tx_lock_o,
   output logic fill_frame_kind_o,
   output logic frame_error_o
);
   int cnt;
   logic strobe_q;
   // lock stays low until the transmitter pll has settled
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cnt <= 0;
         tx_lock_o <= 1'b0;
      end else if (cnt < LOCK_DLY) begin
         cnt <= cnt + 1;
      end else begin
         tx_lock_o <= 1'b1;
      end
   end
   // far end echoes our fill kind back at the next rising strobe
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         strobe_q <= 1'b0;
         fill_frame_kind_o <= 1'b0;
         frame_error_o <= 1'b0;
      end else begin
         strobe_q <= strobe_i;
         if (strobe_i && !strobe_q) begin
            fill_frame_kind_o <= fill_select_i;
            frame_error_o <= err_inj_i;
         end
      end
   end
endmodule
`default_nettype wire

// ==== sim/rsc_startup_tb.sv ====
// bench for the receiver start-up controller
// assumes the far model supplies transmitter lock and fill echo
`timescale 1ns/1ps
`default_nettype none
`include "rsc_map.svh"
module rsc_startup_tb;
   // ----
   // signals
   // ----
   logic clk = 0, arst_n = 0, host_n = 0, lock_rst_n = 0, tsel = 0, external_test_clock = 0, w20 = 0;
   logic err_inj = 0, wr = 0, rd = 0, lo, hi, strb, link_n, phase, restart, lock, ffk, ferr;
   logic [3:0] addr = 4'h0;
   logic [31:0] wdata = 32'h0, rdata;
   int miscompares = 0, checks = 0;
   always #4 clk = ~clk;
   always @(posedge clk) external_test_clock <= ~external_test_clock;
   rsc_startup dut (.sys_clk_i(clk), .arst_n_i(arst_n), .host_startup_reset_n_i(host_n),
      .lock_startup_reset_n_i(lock), .test_clock_select_i(tsel),
      .external_test_clock_i(external_test_clock), .word20_mode_i(w20), .data_frame_valid_i(1'b0),
      .control_frame_valid_i(1'b0), .fill_frame_kind_i(ffk), .frame_error_i(ferr),
      .freq_detector_disable_i(lo), .link_active_i(hi), .reg_addr_i(addr),
      .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
      .startup_state_bit_lo_o(lo), .startup_state_bit_hi_o(hi),
      .recovered_frame_strobe_o(strb), .link_up_n_o(link_n), .pll_phase_mode_o(phase),
      .pll_restart_o(restart));
   rsc_far_model far (.sys_clk_i(clk), .arst_n_i(lock_rst_n), .strobe_i(strb),
      .fill_select_i(lo), .err_inj_i(err_inj), .tx_lock_o(lock),
      .fill_frame_kind_o(ffk), .frame_error_o(ferr));
   // ----
   // tasks
   // ----
   task automatic chk_word(input logic [31:0] act, input logic [31:0] exp);
      checks++;
      if (act !== exp) begin
         miscompares++;
         $display("wrong value at %0t: word %h expected %h", $time, act, exp);
      end
   endtask
   task automatic chk_pin(input logic act, input logic exp);
      checks++;
      if (act !== exp) begin
         miscompares++;
         $display("wrong value at %0t: pin %b expected %b", $time, act, exp);
      end
   endtask
   task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic reg_chk(input logic [3:0] a, input logic [31:0] exp);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 chk_word(rdata, exp);
   endtask
   // frame length and high time, in cycles, from strobe edges
   task automatic per(input int exp);
      time t0, t1, t2;
      @(posedge strb);
      @(posedge strb);
      t0 = $time;
      @(negedge strb);
      t1 = $time;
      @(posedge strb);
      t2 = $time;
      chk_word(32'((t2 - t0) / 8), 32'(exp));
      chk_word(32'((t1 - t0) / 8), 32'(exp / 2));
   endtask
   task automatic wait_st(input logic [1:0] s, input int n);
      for (int i = 0; i < n && {hi, lo} !== s; i++) begin
         @(posedge clk);
         #1;
      end
      #1 chk_word({30'h0, hi, lo}, {30'h0, s});
   endtask
   task automatic end_sim;
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // ----
   // tests
   // ----
   initial begin
      #200000;
      miscompares++;
      end_sim();
   end
   initial begin
      repeat (2) @(posedge clk);
      arst_n <= 1'b1;
      host_n <= 1'b1;
      lock_rst_n <= 1'b1;
      #1 chk_pin(restart, 1'b1);
      reg_chk(`RSC_ADDR_STATUS, 32'h14);
      reg_chk(`RSC_ADDR_CTRL, 32'h80);
      reg_chk(4'h8, 32'h0);
      per(20);
      // errors keep resetting the clean-frame count
      err_inj <= 1'b1;
      repeat (400) @(posedge clk);
      wait_st(2'b00, 1);
      @(posedge clk) err_inj <= 1'b0;
      wait_st(2'b11, 1000);
      repeat (50) @(posedge clk);
      #1 chk_pin(link_n, 1'b0);
      chk_pin(phase, 1'b1);
      reg_chk(`RSC_ADDR_STATUS, 32'h0b);
      reg_wr(`RSC_ADDR_CTRL, 32'h20);
      reg_wr(4'h8, 32'hff);
      reg_chk(`RSC_ADDR_CTRL, 32'h20);
      @(posedge clk) host_n <= 1'b0;
      repeat (2) @(posedge clk);
      #1 wait_st(2'b00, 1);
      chk_pin(restart, 1'b1);
      @(posedge clk) host_n <= 1'b1;
      wait_st(2'b11, 1000);
      // software restart pulse; its bit reads back as zero
      reg_wr(`RSC_ADDR_CTRL, 32'h21);
      @(posedge clk);
      #1 chk_pin(restart, 1'b1);
      wait_st(2'b00, 1);
      reg_chk(`RSC_ADDR_CTRL, 32'h20);
      wait_st(2'b11, 1000);
      @(posedge clk) lock_rst_n <= 1'b0;
      @(posedge clk) lock_rst_n <= 1'b1;
      repeat (20) @(posedge clk);
      wait_st(2'b00, 1);
      chk_pin(restart, 1'b1);
      wait_st(2'b11, 1000);
      @(posedge clk) w20 <= 1'b1;
      per(24);
      tsel <= 1'b1;
      per(48);
      end_sim();
   end
endmodule
`default_nettype wire
